// ==== dv/apmfc_spi_host.sv ====
/*
 * Behavioural serial host that drives the converter's serial pins with a run
 * of ones, closed either by a zero or by chip select rising.
 * Assumes clk_sys paces it; each serial half period lasts four clk_sys cycles.
 */
module apmfc_spi_host
(
    // Clock that paces the serial pins.
    input wire logic clk_sys,
    // Pattern request and its shape.
    input wire logic go,
    input wire logic [10:0] ones,
    input wire logic end_zero,
    output logic busy,
    // Serial pins.
    output logic sclk_pin,
    output logic sdi_pin,
    output logic cs_n_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // Bit count of the frame being sent.
    int nbits;

    // One process owns every pin, so no two drivers ever meet.
    initial
    begin
        busy = 1'b0;
        sclk_pin = 1'b0;
        sdi_pin = 1'b0;
        cs_n_pin = 1'b1;
        forever
        begin
            @(posedge clk_sys);
            if (go === 1'b1)
            begin
                busy <= 1'b1;
                cs_n_pin <= 1'b0;
                nbits = ones + end_zero;
                for (int i = 0; i < nbits; i++)
                begin
                    // Data changes with the rising edge and is taken on the falling one.
                    sdi_pin <= (i < ones);
                    sclk_pin <= 1'b1;
                    repeat (4) @(posedge clk_sys);
                    sclk_pin <= 1'b0;
                    repeat (4) @(posedge clk_sys);
                end
                // Chip select rising closes the frame.
                cs_n_pin <= 1'b1;
                busy <= 1'b0;
            end
            else if (cs_n_pin)
                // A released data line must not keep its last value.
                sdi_pin <= ~sdi_pin;
        end
    end
endmodule

// ==== dv/apmfc_top_tb.sv ====
/*
 * Self-checking bench of the converter power-mode and filter control block.
 * Assumes apmfc_top with shortened conversions and the serial host model.
 */
`include "apmfc_map.svh"

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module apmfc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // Shortened decimation keeps each conversion to a few tens of cycles.
    localparam int S3 = 4;
    localparam int MD = 1;
    localparam int LEN3 = S3 * MD * `APMFC_SINC1_LOW;
    localparam int LEN5 = S3 * MD * `APMFC_SINC1_HIGH;

    logic clk_sys, srst, rst_pin_n, sclk_pin, sdi_pin, cs_n_pin;
    logic avs_read, avs_write, avs_waitrequest, go, end_zero, busy;
    logic cm_out_en_r, speed_high_r, analog_on_r, mod_sample_en_r;
    logic filter_en_r, result_valid_r, drdy_n_r;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [10:0] ones;
    int error_cnt, checks, n;

    apmfc_top #(.SINC3_OSR(S3), .MOD_DIV(MD)) u_apmfc_top
    (
        .clk_sys(clk_sys), .srst(srst), .rst_pin_n(rst_pin_n),
        .sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .cs_n_pin(cs_n_pin),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cm_out_en_r(cm_out_en_r), .speed_high_r(speed_high_r),
        .analog_on_r(analog_on_r), .mod_sample_en_r(mod_sample_en_r),
        .filter_en_r(filter_en_r), .result_valid_r(result_valid_r),
        .drdy_n_r(drdy_n_r)
    );

    apmfc_spi_host u_apmfc_spi_host
    (
        .clk_sys(clk_sys), .go(go), .ones(ones), .end_zero(end_zero),
        .busy(busy), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .cs_n_pin(cs_n_pin)
    );

    // Master clock, 20 MHz.
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One Avalon access; the request stands until waitrequest is seen low.
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        do
            @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask

    // Reads one register and compares the whole word.
    task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask

    // Compares the state field of the status register.
    task automatic st(input logic [1:0] e);
        acc(1'b0, `APMFC_OFS_STAT, 32'h0);
        `CHK("state", e, rd[1:0])
    endtask

    // Lets registered outputs land; sampling just after the edge avoids races.
    task automatic settle(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    // Counts edges until a result pulse is seen; the cap keeps a dead design finite.
    task automatic conv(output int c);
        c = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            c++;
        end
        while (result_valid_r !== 1'b1 && c < 200);
    endtask

    // Stop lets the running conversion finish, so wait for its result.
    task automatic stop_conv();
        wr(`APMFC_OFS_CTRL, 32'h2);
        conv(n);
        settle(2);
    endtask

    // Sends one serial pattern and gives the reset pulse time to land.
    task automatic pat(input logic [10:0] k, input logic z);
        @(posedge clk_sys);
        ones <= k;
        end_zero <= z;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        do
            @(posedge clk_sys);
        while (busy !== 1'b0);
        settle(10);
    endtask

    // Watchdog, far beyond the roughly 25000 cycles the tests need.
    initial
    begin
        #3000000;
        error_cnt++;
        test_done();
    end

    initial
    begin
        error_cnt = 0;
        checks = 0;
        srst = 1'b1;
        rst_pin_n = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        go = 1'b0;
        ones = 11'h0;
        end_zero = 1'b0;
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        settle(1);
        `CHK("cm out", 1'b0, cm_out_en_r)
        `CHK("speed", 1'b1, speed_high_r)
        `CHK("filter", 1'b0, filter_en_r)
        `CHK("drdy", 1'b1, drdy_n_r)
        rchk("cfg2 reset", `APMFC_OFS_CFG2, 32'h4);
        // Common-mode enable; a write without lane 0 must be ignored.
        wr(`APMFC_OFS_CFG1, 32'h1);
        settle(2);
        `CHK("cm on", 1'b1, cm_out_en_r)
        @(posedge clk_sys);
        avs_byteenable <= 4'h0;
        wr(`APMFC_OFS_CFG1, 32'h0);
        avs_byteenable <= 4'hf;
        settle(2);
        `CHK("cm kept", 1'b1, cm_out_en_r)
        wr(`APMFC_OFS_CFG1, 32'h0);
        settle(2);
        `CHK("cm off", 1'b0, cm_out_en_r)
        // Unmapped place and write-only control both read as zero.
        wr(4'h2, 32'hffffffff);
        rchk("unmapped", 4'h2, 32'h0);
        rchk("control", `APMFC_OFS_CTRL, 32'h0);
        wr(`APMFC_OFS_CFG2, 32'h0);
        settle(2);
        `CHK("speed low", 1'b0, speed_high_r)
        // Both sinc1 ratios in idle mode.
        for (int r = 0; r < 2; r++)
        begin
            wr(`APMFC_OFS_CFG2, 32'h4 | (r << `APMFC_CFG2_RATIO_BIT));
            wr(`APMFC_OFS_CTRL, 32'h1);
            conv(n);
            `CHK("length", (r ? LEN5 : LEN3), n)
            `CHK("ready", 1'b0, drdy_n_r)
            rchk("status", `APMFC_OFS_STAT, 32'h6);
            `CHK("filter run", 1'b1, filter_en_r)
            stop_conv();
            `CHK("filter stop", 1'b0, filter_en_r)
            `CHK("idle sampling", 1'b1, mod_sample_en_r)
            st(2'h0);
        end
        // Standby halts sampling and lengthens the first conversion.
        wr(`APMFC_OFS_CFG2, 32'h6);
        wr(`APMFC_OFS_CTRL, 32'h1);
        conv(n);
        stop_conv();
        `CHK("standby sampling", 1'b0, mod_sample_en_r)
        st(2'h1);
        wr(`APMFC_OFS_CTRL, 32'h1);
        conv(n);
        `CHK("restart length", LEN3 + `APMFC_STBY_EXTRA, n)
        stop_conv();
        // Power-down in mid-conversion: no result, registers kept.
        wr(`APMFC_OFS_CFG1, 32'h1);
        wr(`APMFC_OFS_CTRL, 32'h1);
        wr(`APMFC_OFS_CFG2, 32'hd);
        n = 0;
        repeat (LEN5 + 8)
        begin
            settle(1);
            if (result_valid_r !== 1'b0 || drdy_n_r !== 1'b1)
                n++;
        end
        `CHK("pd results", 0, n)
        `CHK("pd analog", 1'b0, analog_on_r)
        `CHK("pd sampling", 1'b0, mod_sample_en_r)
        st(2'h3);
        rchk("pd cfg1", `APMFC_OFS_CFG1, 32'h1);
        rchk("pd cfg2", `APMFC_OFS_CFG2, 32'hd);
        wr(`APMFC_OFS_CFG2, 32'hc);
        settle(2);
        `CHK("exit analog", 1'b1, analog_on_r)
        `CHK("exit sampling", 1'b1, mod_sample_en_r)
        st(2'h0);
        // Only the exact key resets; the reset also ends power-down.
        wr(`APMFC_OFS_CFG2, 32'hd);
        wr(`APMFC_OFS_CTRL, 32'h18);
        settle(4);
        rchk("near key", `APMFC_OFS_CFG1, 32'h1);
        wr(`APMFC_OFS_CTRL, `APMFC_CTRL_RST_KEY);
        settle(4);
        `CHK("key analog", 1'b1, analog_on_r)
        rchk("key cfg2", `APMFC_OFS_CFG2, 32'h4);
        rchk("key cfg1", `APMFC_OFS_CFG1, 32'h0);
        // Reset pin.
        wr(`APMFC_OFS_CFG1, 32'h1);
        rst_pin_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_pin_n <= 1'b1;
        settle(6);
        rchk("pin cfg1", `APMFC_OFS_CFG1, 32'h0);
        // Serial patterns: one one too few, then both accepted forms.
        wr(`APMFC_OFS_CFG1, 32'h1);
        pat(11'h3fe, 1'b1);
        rchk("short run", `APMFC_OFS_CFG1, 32'h1);
        pat(11'h3ff, 1'b1);
        rchk("zero end", `APMFC_OFS_CFG1, 32'h0);
        wr(`APMFC_OFS_CFG1, 32'h1);
        pat(11'h400, 1'b0);
        rchk("cs end", `APMFC_OFS_CFG1, 32'h0);
        test_done();
    end
endmodule

// ==== rtl/apmfc_map.svh ====
/*
 * Register offsets, field positions, reset values and counts of the converter
 * power-mode and filter control block.
 * Assumes byte addressing on a 32-bit Avalon-MM bus, one register per word.
 */
// Behaviour
// - Sinc3 ratio fixed, sinc1 ratio 3 or 5.
// - Output rate follows ratio and speed mode.
// - Common-mode output driven only when enabled.
// - Speed bit selects high or low speed.
// - Standby bit chooses idle or standby when stopped.
// - Idle keeps sampling, only filter is stopped.
// - Standby engages on stop and halts sampling.
// - First conversion after standby lasts 24 more cycles.
// - Power-down stops analog, digital and sampling.
// - Power-down keeps all register contents.
// - Clearing power-down bit or reset resumes operation.
// - Reset reinitialises logic, interface and registers.
// - Power-on, reset pin and serial reset sources.
// - Only control value 58h commands a reset.
// - 1023 ones then zero resets the device.
`ifndef APMFC_MAP_SVH
`define APMFC_MAP_SVH

// Register byte offsets.
`define APMFC_OFS_CFG1 4'h0
`define APMFC_OFS_CFG2 4'h4
`define APMFC_OFS_CTRL 4'h8
`define APMFC_OFS_STAT 4'hc

// First configuration register fields.
`define APMFC_CFG1_CM_BIT 0
`define APMFC_CFG1_RST 1'h0

// Second configuration register fields and reset value.
`define APMFC_CFG2_POWER_DOWN_BIT_BIT 0
`define APMFC_CFG2_STBY_BIT 1
`define APMFC_CFG2_SPEED_BIT 2
`define APMFC_CFG2_RATIO_BIT 3
`define APMFC_CFG2_RST 4'h4

// Control register command bits and the reset key.
`define APMFC_CTRL_START_BIT 0
`define APMFC_CTRL_STOP_BIT 1
`define APMFC_CTRL_RST_KEY 8'h58

// Decimation figures.
`define APMFC_SINC3_OSR 32000
`define APMFC_MOD_DIV 2
`define APMFC_SINC1_LOW 3
`define APMFC_SINC1_HIGH 5

// Extra master clock cycles on the first conversion after standby.
`define APMFC_STBY_EXTRA 24

// Serial reset pattern lengths.
`define APMFC_PAT_ONES_MIN 11'h3ff
`define APMFC_PAT_ONES_CS 11'h400

`endif

// ==== rtl/apmfc_pkg.sv ====
/*
 * Types shared by the converter power-mode and filter control block.
 * Assumes the constants of apmfc_map.svh alongside.
 */
package apmfc_pkg;

    // Operating state of the converter core.
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_STANDBY = 2'b01,
        ST_CONVERT = 2'b10,
        ST_POWER_DOWN_BIT = 2'b11
    } apmfc_state_e;

    // Conversion cycle counter.
    typedef logic [19:0] apmfc_cnt_t;

endpackage

// ==== rtl/apmfc_spi_reset_detect.sv ====
/*
 * Watches the serial pins for the reset pattern: a long run of ones ended by a
 * zero, or a run of at least 1024 ones ended by chip select rising.
 * Assumes the serial pins are asynchronous to clk_sys and that the serial
 * clock is much slower than clk_sys, so every edge is seen after sampling.
 */
`include "apmfc_map.svh"

module apmfc_spi_reset_detect
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic srst,
    // Serial pins.
    input wire logic sclk_pin,
    input wire logic sdi_pin,
    input wire logic cs_n_pin,
    // Reset request, one cycle.
    output logic pat_rst_r
);

    logic [2:0] sclk_s_r; // Two sync stages then an edge history stage.
    logic [1:0] sdi_s_r; // Two sync stages.
    logic [2:0] cs_s_r; // Two sync stages then an edge history stage.
    logic [10:0] ones_r; // Saturating count of consecutive ones.
    logic sclk_fall;
    logic cs_rise;
    logic ones_sat;

    // Edges are taken from the second stage onward only.
    assign sclk_fall = sclk_s_r[2] & ~sclk_s_r[1];
    assign cs_rise = ~cs_s_r[2] & cs_s_r[1];
    assign ones_sat = (ones_r == `APMFC_PAT_ONES_CS);

    // Synchronise the pins; no logic looks at the first stage.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sclk_s_r <= 3'h0;
            sdi_s_r <= 2'h0;
            cs_s_r <= 3'h7;
        end
        else
        begin
            sclk_s_r <= {sclk_s_r[1:0], sclk_pin};
            sdi_s_r <= {sdi_s_r[0], sdi_pin};
            cs_s_r <= {cs_s_r[1:0], cs_n_pin};
        end
    end

    // Count ones on falling serial clock edges and flag the pattern.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ones_r <= 11'h0;
            pat_rst_r <= 1'b0;
        end
        else if (sclk_fall)
        begin
            // The terminating zero is shifted in on this edge.
            pat_rst_r <= ~sdi_s_r[1] & (ones_r >= `APMFC_PAT_ONES_MIN);
            ones_r <= sdi_s_r[1] ? (ones_sat ? ones_r : ones_r + 11'h1) : 11'h0;
        end
        else if (cs_rise)
        begin
            // Four-wire variant: the run is ended by the frame end.
            pat_rst_r <= ones_sat;
            ones_r <= 11'h0;
        end
        else
        begin
            pat_rst_r <= 1'b0;
        end
    end

endmodule

// ==== rtl/apmfc_top.sv ====
/*
 * Power-mode, speed-mode and sinc3+sinc1 decimation control of the converter,
 * with its register file on an Avalon-MM slave and the four reset sources.
 * Assumes clk_sys is the converter master clock and that the host supplies the
 * nominal rate for the chosen speed mode; the analog core obeys the enables.
 */
`include "apmfc_map.svh"

module apmfc_top
#(
    // Sinc3 decimation and modulator divide; shorten in simulation only.
    parameter int SINC3_OSR = `APMFC_SINC3_OSR,
    parameter int MOD_DIV = `APMFC_MOD_DIV
)
(
    // Clock and power-on reset.
    input wire logic clk_sys,
    input wire logic srst,
    // Dedicated reset pin, active low, asynchronous to clk_sys.
    input wire logic rst_pin_n,
    // Serial pins watched for the reset pattern.
    input wire logic sclk_pin,
    input wire logic sdi_pin,
    input wire logic cs_n_pin,
    // Avalon-MM slave.
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Converter core controls.
    output logic cm_out_en_r,
    output logic speed_high_r,
    output logic analog_on_r,
    output logic mod_sample_en_r,
    output logic filter_en_r,
    output logic result_valid_r,
    output logic drdy_n_r
);

    logic [1:0] rpin_s_r; // Reset pin synchroniser.
    logic cmd_rst_r; // Reset commanded over the bus.
    logic pat_rst_r; // Reset from the serial pattern detector.
    logic rst_ext; // Every reset except the serial pattern.
    logic rst_all; // Every reset source together.
    logic wait_r; // Waitrequest, high while idle.
    logic [31:0] rdata_r; // Read data register.
    logic cfg1_cm_r; // Common-mode output enable.
    logic [3:0] cfg2_r; // Second configuration register.
    logic stop_pend_r; // Stop requested, taken at end of conversion.
    logic first_r; // Current conversion is the first after a start.
    apmfc_pkg::apmfc_state_e state_r, state_nxt; // Sequencer state.
    apmfc_pkg::apmfc_cnt_t cnt_r, cnt_nxt; // Master clocks left in the conversion.
    logic wr_acc, rd_take; // Write taken and read latched at this edge.
    logic wr_cfg1, wr_cfg2, wr_ctrl; // Register write strobes.
    logic rst_key, start_req, stop_req; // Control register commands.
    logic power_down_bit, stby_sel, ratio_hi, conv_done; // Decoded fields and end of conversion.
    logic [31:0] rd_mux; // Read data before it is registered.

    // Length of one conversion in master clocks, with the standby penalty.
    function automatic apmfc_pkg::apmfc_cnt_t conv_len(input logic hi, input logic extra);
        int n;
        n = MOD_DIV * SINC3_OSR * (hi ? `APMFC_SINC1_HIGH : `APMFC_SINC1_LOW);
        if (extra)
        begin
            n = n + `APMFC_STBY_EXTRA;
        end
        return apmfc_pkg::apmfc_cnt_t'(n);
    endfunction

    // Serial reset pattern detector; it is reset by the other sources too.
    apmfc_spi_reset_detect u_pat
    (
        .clk_sys(clk_sys),
        .srst(rst_ext),
        .sclk_pin(sclk_pin),
        .sdi_pin(sdi_pin),
        .cs_n_pin(cs_n_pin),
        .pat_rst_r(pat_rst_r)
    );

    // Reset pin synchroniser; only power-on reset initialises it, to the released level.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rpin_s_r <= 2'h3;
        end
        else
        begin
            rpin_s_r <= {rpin_s_r[0], rst_pin_n};
        end
    end

    // All reset sources merge here and clear the block, except the pin synchroniser and the pattern detector.
    assign rst_ext = srst | ~rpin_s_r[1] | cmd_rst_r;
    assign rst_all = rst_ext | pat_rst_r;

    // Bus decode.
    assign wr_acc = avs_write & ~wait_r;
    assign rd_take = avs_read & wait_r;
    assign wr_cfg1 = wr_acc & avs_byteenable[0] & (avs_address == `APMFC_OFS_CFG1);
    assign wr_cfg2 = wr_acc & avs_byteenable[0] & (avs_address == `APMFC_OFS_CFG2);
    assign wr_ctrl = wr_acc & avs_byteenable[0] & (avs_address == `APMFC_OFS_CTRL);
    assign rst_key = wr_ctrl & (avs_writedata[7:0] == `APMFC_CTRL_RST_KEY);
    assign start_req = wr_ctrl & ~rst_key & avs_writedata[`APMFC_CTRL_START_BIT];
    assign stop_req = wr_ctrl & ~rst_key & avs_writedata[`APMFC_CTRL_STOP_BIT];

    // Configuration fields.
    assign power_down_bit = cfg2_r[`APMFC_CFG2_POWER_DOWN_BIT_BIT];
    assign stby_sel = cfg2_r[`APMFC_CFG2_STBY_BIT];
    assign ratio_hi = cfg2_r[`APMFC_CFG2_RATIO_BIT];
    assign conv_done = (state_r == apmfc_pkg::ST_CONVERT) & (cnt_r == 20'h1);

    // Read multiplexer; unmapped offsets and the control register read zero.
    assign rd_mux = (avs_address == `APMFC_OFS_CFG1) ? {31'h0, cfg1_cm_r} :
                    (avs_address == `APMFC_OFS_CFG2) ? {28'h0, cfg2_r} :
                    (avs_address == `APMFC_OFS_STAT) ?
                    {27'h0, first_r, stop_pend_r, ~drdy_n_r, state_r} : 32'h0;

    // Every request waits one cycle, then is answered in the next.
    always_ff @(posedge clk_sys)
    begin
        if (rst_all)
        begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0;
        end
        else
        begin
            wait_r <= ~((avs_read | avs_write) & wait_r);
            rdata_r <= rd_take ? rd_mux : rdata_r;
        end
    end

    // Register file; power-down leaves it untouched, only reset clears it.
    always_ff @(posedge clk_sys)
    begin
        if (rst_all)
        begin
            cfg1_cm_r <= `APMFC_CFG1_RST;
            cfg2_r <= `APMFC_CFG2_RST;
            cmd_rst_r <= 1'b0;
        end
        else
        begin
            cfg1_cm_r <= wr_cfg1 ? avs_writedata[`APMFC_CFG1_CM_BIT] : cfg1_cm_r;
            cfg2_r <= wr_cfg2 ? avs_writedata[3:0] : cfg2_r;
            cmd_rst_r <= rst_key;
        end
    end

    // Next state and counter of the conversion sequencer.
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            apmfc_pkg::ST_IDLE:
            begin
                // Modulator keeps sampling; a start enables the filter.
                if (start_req)
                begin
                    state_nxt = apmfc_pkg::ST_CONVERT;
                    cnt_nxt = conv_len(ratio_hi, 1'b0);
                end
                else if (stby_sel)
                begin
                    state_nxt = apmfc_pkg::ST_STANDBY;
                end
            end
            apmfc_pkg::ST_STANDBY:
            begin
                // Restart from standby pays the stabilising penalty.
                if (start_req)
                begin
                    state_nxt = apmfc_pkg::ST_CONVERT;
                    cnt_nxt = conv_len(ratio_hi, 1'b1);
                end
                else if (!stby_sel)
                begin
                    state_nxt = apmfc_pkg::ST_IDLE;
                end
            end
            apmfc_pkg::ST_CONVERT:
            begin
                if (start_req)
                begin
                    // A second start restarts the ongoing conversion.
                    cnt_nxt = conv_len(ratio_hi, 1'b0);
                end
                else if (conv_done)
                begin
                    // The stop lands only once the running conversion ends.
                    state_nxt = stop_pend_r ?
                                (stby_sel ? apmfc_pkg::ST_STANDBY : apmfc_pkg::ST_IDLE) :
                                apmfc_pkg::ST_CONVERT;
                    cnt_nxt = conv_len(ratio_hi, 1'b0);
                end
                else
                begin
                    cnt_nxt = cnt_r - 20'h1;
                end
            end
            apmfc_pkg::ST_POWER_DOWN_BIT:
            begin
                // Conversions are not resumed on exit; software starts them.
                if (!power_down_bit)
                begin
                    state_nxt = stby_sel ? apmfc_pkg::ST_STANDBY :
                                apmfc_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = apmfc_pkg::ST_IDLE;
            end
        endcase
        // Power-down overrides everything, even a start written with it.
        if (power_down_bit)
        begin
            state_nxt = apmfc_pkg::ST_POWER_DOWN_BIT;
        end
    end

    // Sequencer registers.
    always_ff @(posedge clk_sys)
    begin
        if (rst_all)
        begin
            state_r <= apmfc_pkg::ST_IDLE;
            cnt_r <= 20'h0;
            stop_pend_r <= 1'b0;
            first_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            stop_pend_r <= ~start_req & (stop_req | (stop_pend_r & ~conv_done));
            first_r <= start_req | (first_r & ~conv_done);
        end
    end

    // Core enables and ready flag, all registered.
    always_ff @(posedge clk_sys)
    begin
        if (rst_all)
        begin
            cm_out_en_r <= 1'b0;
            speed_high_r <= 1'b1;
            analog_on_r <= 1'b1;
            mod_sample_en_r <= 1'b1;
            filter_en_r <= 1'b0;
            result_valid_r <= 1'b0;
            drdy_n_r <= 1'b1;
        end
        else
        begin
            // The common-mode buffer is part of the analog section.
            cm_out_en_r <= cfg1_cm_r & ~power_down_bit;
            // The host must match the master clock to this mode.
            speed_high_r <= cfg2_r[`APMFC_CFG2_SPEED_BIT];
            analog_on_r <= (state_nxt != apmfc_pkg::ST_POWER_DOWN_BIT);
            mod_sample_en_r <= (state_nxt == apmfc_pkg::ST_IDLE) |
                               (state_nxt == apmfc_pkg::ST_CONVERT);
            filter_en_r <= (state_nxt == apmfc_pkg::ST_CONVERT);
            result_valid_r <= conv_done & ~power_down_bit & ~start_req;
            drdy_n_r <= (start_req | power_down_bit) ? 1'b1 :
                        ((conv_done & ~power_down_bit) ? 1'b0 : drdy_n_r);
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;

    // Common-mode output is off one edge after its enable bit is seen low.
    property p_cm_off;
        @(posedge clk_sys) disable iff (rst_all)
        !cfg1_cm_r |=> !cm_out_en_r;
    endproperty
    a_cm_off: assert property (p_cm_off) else $error("common-mode enable leaked");
    // Idle samples but does not filter.
    property p_idle;
        @(posedge clk_sys) disable iff (rst_all)
        (state_r == apmfc_pkg::ST_IDLE) && !power_down_bit && !start_req && !stby_sel
        |=> mod_sample_en_r && !filter_en_r;
    endproperty
    a_idle: assert property (p_idle) else $error("idle enables wrong");
    // Standby halts sampling.
    property p_stby;
        @(posedge clk_sys) disable iff (rst_all)
        (state_r == apmfc_pkg::ST_STANDBY) && stby_sel && !power_down_bit && !start_req
        |=> !mod_sample_en_r;
    endproperty
    a_stby: assert property (p_stby) else $error("standby still sampling");
    // Start from standby loads the longer first conversion.
    property p_stby_len;
        @(posedge clk_sys) disable iff (rst_all)
        (state_r == apmfc_pkg::ST_STANDBY) && start_req && !power_down_bit
        |=> cnt_r == conv_len($past(ratio_hi), 1'b0) + `APMFC_STBY_EXTRA;
    endproperty
    a_stby_len: assert property (p_stby_len) else $error("standby penalty wrong");
    // Power-down turns everything off and yields no results.
    property p_power_down_bit;
        @(posedge clk_sys) disable iff (rst_all)
        power_down_bit |=> !analog_on_r && !mod_sample_en_r && !result_valid_r ##1 drdy_n_r;
    endproperty
    a_power_down_bit: assert property (p_power_down_bit) else $error("power-down leaks");
    // The second configuration register holds unless written.
    property p_hold;
        @(posedge clk_sys) disable iff (rst_all)
        !wr_cfg2 |=> $stable(cfg2_r);
    endproperty
    a_hold: assert property (p_hold) else $error("config changed by itself");
    // Clearing power-down leaves the state on the next edge.
    property p_exit;
        @(posedge clk_sys) disable iff (rst_all)
        (state_r == apmfc_pkg::ST_POWER_DOWN_BIT) && !power_down_bit |=> state_r != apmfc_pkg::ST_POWER_DOWN_BIT;
    endproperty
    a_exit: assert property (p_exit) else $error("power-down not left");
    // Only the key commands a reset; the command reset itself must not disable the check.
    property p_key;
        @(posedge clk_sys) disable iff (srst | pat_rst_r | ~rpin_s_r[1])
        wr_ctrl |=> cmd_rst_r == ($past(avs_writedata[7:0]) == `APMFC_CTRL_RST_KEY);
    endproperty
    a_key: assert property (p_key) else $error("reset key decode wrong");
    // A pin, command or pattern reset restores the defaults one edge later.
    property p_rst;
        @(posedge clk_sys) disable iff (srst)
        rst_all |=> cfg2_r == `APMFC_CFG2_RST && !cfg1_cm_r && state_r == apmfc_pkg::ST_IDLE;
    endproperty
    a_rst: assert property (p_rst) else $error("reset defaults wrong");

endmodule
